// file: hdl/gcsm_params.svh
// Constants of the gripper command state machine: register offsets,
// field positions and reset values.
// Assumes inclusion by bare name from design files.
`ifndef GCSM_PARAMS_SVH
`define GCSM_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define GCSM_ADDR_CTRL   12'h000
`define GCSM_ADDR_STAT   12'h004
`define GCSM_ADDR_POS    12'h008
`define GCSM_ADDR_CFG    12'h00c
`define GCSM_ADDR_EVT    12'h010
`define GCSM_ADDR_GRIP   12'h020
`define GCSM_ADDR_SW     12'h030
`define GCSM_ADDR_BLK_M  12'hff0

// ****************************************************************
// Field positions
// ****************************************************************
`define GCSM_CTRL_EN     0
`define GCSM_CTRL_HOME   1
`define GCSM_CTRL_GRIP   2
`define GCSM_CTRL_IDX_LO 4
`define GCSM_CFG_REFIN   0
`define GCSM_STAT_SW_LO  8

// ****************************************************************
// Reset values
// ****************************************************************
`define GCSM_CTRL_RST    32'h0000_0000
`define GCSM_CFG_RST     1'b0
`define GCSM_GRIP_RST    32'h0000_0000
`define GCSM_SW_RST      32'h0000_0000
`define GCSM_EVT_RST     16'h0000

`endif

// file: hdl/gcsm_pkg.sv
// Types of the gripper command state machine.
// Assumes nothing of its surroundings.
package gcsm_pkg;

    // Gripping control states
    typedef enum logic [2:0] {
        GCSM_UNINIT,
        GCSM_REF,
        GCSM_IDLE,
        GCSM_MOVE,
        GCSM_RELEASED,
        GCSM_NOPART,
        GCSM_HOLDING,
        GCSM_FAULT
    } gcsm_state_e;

    // Drive force selection
    typedef enum logic [1:0] {
        GCSM_F_NONE,
        GCSM_F_REF,
        GCSM_F_REDUCED,
        GCSM_F_GRIP
    } gcsm_force_e;

endpackage : gcsm_pkg

// file: hdl/gcsm_top.sv
// Gripper command state machine with APB register file.
// Assumes pclk at 10 MHz, jaw position and stall/error inputs
// synchronous to pclk, and a motor stage that follows the drive outputs.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "gcsm_params.svh"

module gcsm_top #(
    parameter int             POS_W  = 16,
    parameter logic [15:0]    STROKE = 16'h07d0
) (
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Motor stage feedback
    input  wire logic [POS_W-1:0]  pos_raw,
    input  wire logic              jaw_stall,
    input  wire logic              int_err,
    input  wire logic [15:0]       err_code,
    // Drive control
    output logic                   drive_on,
    output logic                   move_on,
    output logic                   move_out,
    output gcsm_pkg::gcsm_force_e  force_sel,
    output logic                   pos_hold,
    output logic                   part_monitor,
    // State report
    output logic      [4:0]        grip_flags,
    output logic      [3:0]        vsw_state,
    output logic      [POS_W-1:0]  jaw_pos,
    output logic                   sys_event,
    output logic      [15:0]       event_code
);
    import gcsm_pkg::*;

    // ************************************************************
    // Register file
    // ************************************************************
    logic [31:0]      ctrl_reg;
    logic             cfg_reg;
    logic [31:0]      grip_reg [4];
    logic [31:0]      sw_reg   [4];
    logic [31:0]      prdata_reg;
    logic [15:0]      evt_reg;
    logic             evt_pulse_reg;

    // Address decode
    wire              wr_acc   = psel & penable & pwrite;
    wire [1:0]        rsel     = paddr[3:2];
    wire              hit_ctrl = (paddr == `GCSM_ADDR_CTRL);
    wire              hit_stat = (paddr == `GCSM_ADDR_STAT);
    wire              hit_pos  = (paddr == `GCSM_ADDR_POS);
    wire              hit_cfg  = (paddr == `GCSM_ADDR_CFG);
    wire              hit_evt  = (paddr == `GCSM_ADDR_EVT);
    wire              hit_grip = ((paddr & `GCSM_ADDR_BLK_M) ==
                                  `GCSM_ADDR_GRIP) && (paddr[1:0] == 2'h0);
    wire              hit_sw   = ((paddr & `GCSM_ADDR_BLK_M) ==
                                  `GCSM_ADDR_SW) && (paddr[1:0] == 2'h0);
    wire              hit_any  = hit_ctrl | hit_stat | hit_pos | hit_cfg |
                                 hit_evt | hit_grip | hit_sw;
    wire [31:0]       stat_word = {20'h0_0000, vsw_state, 3'h0, grip_flags};
    wire [31:0]       rd_mux   =
        hit_ctrl ? ctrl_reg :
        hit_stat ? stat_word :
        hit_pos  ? {{(32-POS_W){1'b0}}, jaw_pos} :
        hit_cfg  ? {31'h0000_0000, cfg_reg} :
        hit_evt  ? {16'h0000, evt_reg} :
        hit_grip ? grip_reg[rsel] :
        hit_sw   ? sw_reg[rsel] : 32'h0000_0000;

    // Zero wait states, error on unmapped access
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata  = prdata_reg;

    // Command fields
    wire              cmd_en   = ctrl_reg[`GCSM_CTRL_EN];
    wire              cmd_home = ctrl_reg[`GCSM_CTRL_HOME];
    wire              cmd_grip = ctrl_reg[`GCSM_CTRL_GRIP];
    wire [1:0]        grip_idx = ctrl_reg[`GCSM_CTRL_IDX_LO +: 2];

    // Register writes and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= `GCSM_CTRL_RST;
            cfg_reg    <= `GCSM_CFG_RST;
            prdata_reg <= 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                grip_reg[i] <= `GCSM_GRIP_RST;
                sw_reg[i]   <= `GCSM_SW_RST;
            end
        end else begin
            if (psel && !penable) prdata_reg <= rd_mux;
            if (wr_acc && hit_ctrl) ctrl_reg <= pwdata;
            if (wr_acc && hit_cfg) cfg_reg <= pwdata[`GCSM_CFG_REFIN];
            if (wr_acc && hit_grip) grip_reg[rsel] <= pwdata;
            if (wr_acc && hit_sw) sw_reg[rsel] <= pwdata;
        end
    end

    // ************************************************************
    // Position and grip window
    // ************************************************************
    gcsm_state_e      state_reg;
    gcsm_state_e      state_next;
    logic [POS_W-1:0] offs_reg;
    logic [POS_W-1:0] pos_reg;
    logic             exec_grip_reg;
    logic             home_prev_reg;
    logic [3:0]       vsw_reg;

    // Selected grip limits; index latched at command start
    logic [1:0]       act_idx_reg;
    wire [POS_W-1:0]  lim_np  = POS_W'(grip_reg[act_idx_reg][15:0]);
    wire [POS_W-1:0]  lim_rel = POS_W'(grip_reg[act_idx_reg][31:16]);
    wire              grip_out = (lim_np > lim_rel);
    wire              dir_out  = exec_grip_reg ? grip_out : ~grip_out;
    wire [POS_W-1:0]  win_lo   = grip_out ? lim_rel : lim_np;
    wire [POS_W-1:0]  win_hi   = grip_out ? lim_np : lim_rel;
    wire              in_win   = (pos_reg > win_lo) && (pos_reg < win_hi);
    wire [POS_W-1:0]  tgt      = exec_grip_reg ? lim_np : lim_rel;
    wire              at_tgt   = dir_out ? (pos_reg >= tgt) :
                                           (pos_reg <= tgt);
    wire [POS_W-1:0]  ref_pos  = cfg_reg ? '0 : POS_W'(STROKE);
    // Referenced position of this cycle, feeds position and switches alike
    wire [POS_W-1:0]  pos_now  = pos_raw - offs_reg;

    // Command decode
    wire              home_rise = cmd_home & ~home_prev_reg;
    wire              new_cmd   = (cmd_grip != exec_grip_reg);
    wire              op_state  = (state_reg == GCSM_RELEASED) ||
                                  (state_reg == GCSM_NOPART) ||
                                  (state_reg == GCSM_HOLDING);

    // Virtual switches: momentary window compare
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_vsw
            wire [POS_W:0] c  = {1'b0, POS_W'(sw_reg[g][15:0])};
            wire [POS_W:0] hw = {1'b0, POS_W'(sw_reg[g][31:17])};
            wire [POS_W:0] p  = {1'b0, pos_now};
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) vsw_reg[g] <= 1'b0;
                else vsw_reg[g] <= (p + hw >= c) && (p <= c + hw);
            end
        end
    endgenerate

    // ************************************************************
    // Gripping state machine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            GCSM_UNINIT: begin
                if (cmd_en && cmd_home) state_next = GCSM_REF;
            end
            GCSM_REF: begin
                if (!cmd_en) state_next = GCSM_UNINIT;
                else if (jaw_stall) state_next = GCSM_IDLE;
            end
            GCSM_IDLE: begin
                if (cmd_en && home_rise) state_next = GCSM_REF;
                else if (cmd_en && !cmd_home) state_next = GCSM_MOVE;
            end
            GCSM_MOVE: begin
                if (!cmd_en) state_next = GCSM_IDLE;
                else if (cmd_home && home_rise) state_next = GCSM_REF;
                else if (at_tgt)
                    state_next = exec_grip_reg ? GCSM_NOPART :
                                                 GCSM_RELEASED;
                else if (jaw_stall && exec_grip_reg && in_win)
                    state_next = GCSM_HOLDING;
                else if (jaw_stall)
                    state_next = exec_grip_reg ? GCSM_NOPART :
                                                 GCSM_RELEASED;
            end
            GCSM_FAULT: begin
                if (!cmd_en && !cmd_home) state_next = GCSM_UNINIT;
            end
            default: begin
                if (!cmd_en) state_next = GCSM_IDLE;
                else if (home_rise) state_next = GCSM_REF;
                else if (new_cmd) state_next = GCSM_MOVE;
            end
        endcase
        if (int_err && state_reg != GCSM_FAULT)
            state_next = GCSM_FAULT;
    end

    // State, position and command tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= GCSM_UNINIT;
            offs_reg      <= '0;
            pos_reg       <= '0;
            exec_grip_reg <= 1'b0;
            act_idx_reg   <= 2'h0;
            home_prev_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            home_prev_reg <= cmd_home;
            pos_reg       <= pos_now;
            if (state_reg == GCSM_REF && state_next == GCSM_IDLE)
                offs_reg <= pos_raw - ref_pos;
            if (state_next == GCSM_MOVE && state_reg != GCSM_MOVE) begin
                exec_grip_reg <= cmd_grip;
                act_idx_reg   <= grip_idx;
            end
        end
    end

    // Fault event capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_reg       <= `GCSM_EVT_RST;
            evt_pulse_reg <= 1'b0;
        end else begin
            evt_pulse_reg <= int_err && state_reg != GCSM_FAULT;
            if (int_err && state_reg != GCSM_FAULT) evt_reg <= err_code;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // One-hot flags {fault, holding, nopart, released, idle}
    assign grip_flags[0] = (state_reg == GCSM_IDLE);
    assign grip_flags[1] = (state_reg == GCSM_RELEASED);
    assign grip_flags[2] = (state_reg == GCSM_NOPART);
    assign grip_flags[3] = (state_reg == GCSM_HOLDING);
    assign grip_flags[4] = (state_reg == GCSM_FAULT);

    // Drive control from state
    assign move_on      = (state_reg == GCSM_REF) ||
                          (state_reg == GCSM_MOVE);
    assign drive_on     = move_on | op_state;
    assign move_out     = (state_reg == GCSM_REF) ? ~cfg_reg : dir_out;
    assign pos_hold     = (state_reg == GCSM_RELEASED) ||
                          (state_reg == GCSM_NOPART);
    assign part_monitor = (state_reg == GCSM_HOLDING);
    assign force_sel    = (state_reg == GCSM_REF)  ? GCSM_F_REF :
                          pos_hold                 ? GCSM_F_REDUCED :
                          drive_on                 ? GCSM_F_GRIP :
                                                     GCSM_F_NONE;
    assign vsw_state    = vsw_reg;
    assign jaw_pos      = pos_reg;
    assign sys_event    = evt_pulse_reg;
    assign event_code   = evt_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ref_abort;
        state_reg == GCSM_REF && !cmd_en && !int_err;
    endsequence
    sequence s_fault_ack;
        state_reg == GCSM_FAULT && !cmd_en && !cmd_home && !int_err;
    endsequence
    sequence s_rel_done;
        state_reg == GCSM_MOVE && cmd_en && !home_rise && !int_err &&
        !exec_grip_reg && at_tgt;
    endsequence

    property p_uninit_flags;
        state_reg == GCSM_UNINIT |-> grip_flags == 5'h00;
    endproperty
    a_uninit_flags: assert property (p_uninit_flags)
        else $error("flags set while uninitialised");

    property p_onehot;
        $onehot0(grip_flags);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one state flag set");

    property p_disable;
        !cmd_en |=> !drive_on && force_sel == GCSM_F_NONE;
    endproperty
    a_disable: assert property (p_disable)
        else $error("drive on after disable");

    property p_move_ref;
        $rose(state_reg == GCSM_MOVE) |->
            $past(state_reg) inside {GCSM_IDLE, GCSM_RELEASED,
                                     GCSM_NOPART, GCSM_HOLDING};
    endproperty
    a_move_ref: assert property (p_move_ref)
        else $error("move started without reference");

    property p_ref_abort;
        s_ref_abort |=> grip_flags == 5'h00 && !drive_on ##1
            state_reg == GCSM_UNINIT || cmd_en;
    endproperty
    a_ref_abort: assert property (p_ref_abort)
        else $error("reference abort failed");

    property p_fault_ack;
        s_fault_ack |=> state_reg == GCSM_UNINIT && grip_flags == 5'h00;
    endproperty
    a_fault_ack: assert property (p_fault_ack)
        else $error("fault not acknowledged");

    property p_released;
        s_rel_done |=> grip_flags == 5'h02 && pos_hold &&
                       force_sel == GCSM_F_REDUCED;
    endproperty
    a_released: assert property (p_released)
        else $error("release limit not reported");

    property p_fault_evt;
        int_err && state_reg != GCSM_FAULT |=>
            grip_flags[4] && sys_event && event_code == $past(err_code);
    endproperty
    a_fault_evt: assert property (p_fault_evt)
        else $error("fault without event");

    property p_new_cmd;
        op_state && cmd_en && !home_rise && new_cmd && !int_err |=>
            grip_flags != $past(grip_flags);
    endproperty
    a_new_cmd: assert property (p_new_cmd)
        else $error("command without state change");

    property p_ref_dir;
        state_reg == GCSM_REF |->
            move_out == !cfg_reg && force_sel == GCSM_F_REF;
    endproperty
    a_ref_dir: assert property (p_ref_dir)
        else $error("wrong reference direction or force");

    property p_grip_dir;
        state_reg == GCSM_MOVE && exec_grip_reg |->
            move_out == (lim_np > lim_rel);
    endproperty
    a_grip_dir: assert property (p_grip_dir)
        else $error("wrong gripping direction");

endmodule : gcsm_top

// file: test/gcsm_jaw_model.sv
// Behavioural jaw and motor stage driven by the gripper drive outputs.
// Assumes pclk domain, one position step per cycle while commanded.
`timescale 1ns/1ps

module gcsm_jaw_model #(
    parameter logic [15:0] STROKE  = 16'h0040,
    parameter logic [15:0] RAW_OFS = 16'h0100
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Drive commands
    input  wire logic        drive_on,
    input  wire logic        move_on,
    input  wire logic        move_out,
    // Part placed between the jaws
    input  wire logic        part_en,
    input  wire logic [15:0] part_at,
    // Sensor feedback
    output logic      [15:0] pos_raw,
    output logic             jaw_stall
);
    logic [15:0] true_reg;
    logic        blocked;

    // Hard stops and the part block the jaws
    assign blocked   = move_out ? (true_reg == STROKE) :
                       (true_reg == 16'h0000 ||
                        (part_en && true_reg == part_at));
    assign pos_raw   = true_reg + RAW_OFS;  // Relative sensor, unknown zero
    assign jaw_stall = drive_on & move_on & blocked;

    // Jaws travel only while powered and commanded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            true_reg <= 16'h0020;
        end else if (drive_on && move_on && !blocked) begin
            true_reg <= move_out ? true_reg + 16'h0001
                                 : true_reg - 16'h0001;
        end
    end
endmodule : gcsm_jaw_model

// file: test/tb_top.sv
// Self-checking bench of the gripper state machine over APB.
// Assumes the jaw model as far side and the register map of the params.
`timescale 1ns/1ps
`include "gcsm_params.svh"

module tb_top;
    import gcsm_pkg::*;
    localparam logic [15:0] STROKE = 16'h0040;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] pos_raw, err_code, jaw_pos, event_code, part_at;
    logic jaw_stall, int_err, drive_on, move_on, move_out, pos_hold;
    logic part_monitor, sys_event, part_en, erv;
    logic [4:0] grip_flags;
    logic [3:0] vsw_state;
    gcsm_force_e force_sel;
    int n_fail, checks_done;

    gcsm_top #(.STROKE(STROKE)) gcsm_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pos_raw(pos_raw),
        .jaw_stall(jaw_stall), .int_err(int_err), .err_code(err_code),
        .drive_on(drive_on), .move_on(move_on), .move_out(move_out),
        .force_sel(force_sel), .pos_hold(pos_hold),
        .part_monitor(part_monitor), .grip_flags(grip_flags),
        .vsw_state(vsw_state), .jaw_pos(jaw_pos), .sys_event(sys_event),
        .event_code(event_code));

    gcsm_jaw_model #(.STROKE(STROKE)) gcsm_jaw_model_inst (
        .pclk(pclk), .presetn(presetn), .drive_on(drive_on),
        .move_on(move_on), .move_out(move_out), .part_en(part_en),
        .part_at(part_at), .pos_raw(pos_raw), .jaw_stall(jaw_stall));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : check

    // One APB transfer, result left in rdv and erv
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_flags(input logic [4:0] f);
        int i;
        for (i = 0; i < 2000 && grip_flags !== f; i++)
            @(negedge pclk);
        check({27'h0, grip_flags}, {27'h0, f});
    endtask : wait_flags

    // Command write, then direction checked on the second falling edge after the write
    task move(input logic [31:0] c, input logic dir);
        apb(1'b1, `GCSM_ADDR_CTRL, c);
        repeat (2) @(negedge pclk);
        check({31'h0, move_out}, {31'h0, dir});
    endtask : move

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Clock of 100 ns
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Watchdog well beyond the test length
    initial begin
        repeat (50000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end

    // At most one state flag at a time
    always @(negedge pclk) begin
        if (presetn === 1'b1) begin
            check({31'h0, $countones(grip_flags) > 1}, 32'h0);
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, int_err, part_en} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_code = 16'h0000;
        part_at = 16'h0020;
        n_fail = 0;
        checks_done = 0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `GCSM_ADDR_STAT, 32'h0);
        check(rdv, 32'h0);
        apb(1'b0, `GCSM_ADDR_CFG, 32'h0);
        check(rdv, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        check({31'h0, erv}, 32'h1);
        check(rdv, 32'h0);
        // Grip refused before referencing
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h5);
        repeat (10) @(negedge pclk);
        check({27'h0, grip_flags}, 32'h0);
        check({31'h0, drive_on}, 32'h0);
        // Grip sets: inward, outward-stall release, outward grip
        apb(1'b1, `GCSM_ADDR_GRIP, 32'h0030_0010);
        apb(1'b1, `GCSM_ADDR_GRIP + 12'h004, 32'h0050_0010);
        apb(1'b1, `GCSM_ADDR_GRIP + 12'h008, 32'h0018_0038);
        apb(1'b1, `GCSM_ADDR_SW, 32'h0008_0010);
        // Outer reference run
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h0);
        move(32'h3, 1'b1);
        check({30'h0, force_sel}, {30'h0, GCSM_F_REF});
        wait_flags(5'h01);
        repeat (2) @(negedge pclk);
        check({16'h0, jaw_pos}, {16'h0, STROKE});
        apb(1'b0, `GCSM_ADDR_POS, 32'h0);
        check(rdv, {16'h0, STROKE});
        // Release, grip onto a part, release again
        move(32'h1, 1'b1);
        wait_flags(5'h02);
        check({31'h0, pos_hold}, 32'h1);
        check({30'h0, force_sel}, {30'h0, GCSM_F_REDUCED});
        part_en <= 1'b1;
        move(32'h5, 1'b0);
        wait_flags(5'h08);
        check({31'h0, part_monitor}, 32'h1);
        check({30'h0, force_sel}, {30'h0, GCSM_F_GRIP});
        check({16'h0, jaw_pos}, 32'h0020);
        move(32'h1, 1'b1);
        wait_flags(5'h02);
        check({28'h0, vsw_state}, 32'h0);
        // Empty grip reaches the no-part limit inside switch window
        part_en <= 1'b0;
        move(32'h5, 1'b0);
        wait_flags(5'h04);
        check({31'h0, vsw_state[0]}, 32'h1);
        apb(1'b0, `GCSM_ADDR_STAT, 32'h0);
        check(rdv & 32'h0000_0f1f, 32'h0000_0104);
        // Set 1 release stalls at the stop outside the switch window
        move(32'h11, 1'b1);
        wait_flags(5'h02);
        check({31'h0, vsw_state[0]}, 32'h0);
        // Set 2 grips outward
        move(32'h25, 1'b1);
        wait_flags(5'h04);
        move(32'h21, 1'b0);
        wait_flags(5'h02);
        move(32'h25, 1'b1);
        wait_flags(5'h04);
        // Disable leaves the jaws force-free
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h0);
        wait_flags(5'h01);
        check({31'h0, drive_on}, 32'h0);
        check({30'h0, force_sel}, {30'h0, GCSM_F_NONE});
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h1);
        wait_flags(5'h02);
        check({31'h0, drive_on}, 32'h1);
        // Internal fault with event pulse, then acknowledge
        err_code <= 16'h1800;
        int_err  <= 1'b1;
        for (int i = 0; i < 10 && sys_event !== 1'b1; i++) @(negedge pclk);
        check({31'h0, sys_event}, 32'h1);
        @(negedge pclk);
        check({31'h0, sys_event}, 32'h0);
        check({27'h0, grip_flags}, 32'h10);
        int_err <= 1'b0;
        apb(1'b0, `GCSM_ADDR_EVT, 32'h0);
        check(rdv & 32'hffff, 32'h1800);
        check({16'h0, event_code}, 32'h1800);
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h0);
        wait_flags(5'h00);
        // Reference aborted by clearing enable
        move(32'h3, 1'b1);
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h2);
        repeat (5) @(negedge pclk);
        check({27'h0, grip_flags}, 32'h0);
        check({31'h0, move_on}, 32'h0);
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h0);
        // Inner reference run
        apb(1'b1, `GCSM_ADDR_CFG, 32'h1);
        move(32'h3, 1'b0);
        wait_flags(5'h01);
        repeat (2) @(negedge pclk);
        check({16'h0, jaw_pos}, 32'h0);
        // Re-reference from a result state on a rising home bit
        apb(1'b1, `GCSM_ADDR_CTRL, 32'h1);
        wait_flags(5'h02);
        move(32'h3, 1'b0);
        check({27'h0, grip_flags}, 32'h0);
        wait_flags(5'h01);
        wrap_up();
    end
endmodule : tb_top
